// >>> design/ddrci_core.sv
// DDR3 command interface: sampling, decode, power and termination
`timescale 1ns/1ns
`default_nettype none
module ddrci_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Link clock pair
    input wire logic ck_t,
    input wire logic ck_c,
    // Control pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt,
    // Address pins
    input wire logic [ddrci_pkg::BA_W-1:0] ba,
    input wire logic [ddrci_pkg::ADDR_W-1:0] addr,
    // Write data pins
    input wire logic [ddrci_pkg::DQ_W-1:0] dq,
    input wire logic [ddrci_pkg::DM_W-1:0] dm,
    // Activate report
    output logic act_valid,
    output logic [ddrci_pkg::BA_W-1:0] act_bank,
    output logic [ddrci_pkg::ADDR_W-1:0] act_row,
    // Read and write report
    output logic rw_valid,
    output logic rw_write,
    output logic [ddrci_pkg::BA_W-1:0] rw_bank,
    output logic [ddrci_pkg::ADDR_W-1:0] rw_col,
    output logic rw_auto_pre,
    output logic rw_burst_full,
    // Precharge report
    output logic pre_valid,
    output logic pre_all,
    output logic [ddrci_pkg::BA_W-1:0] pre_bank,
    // Mode register load report
    output logic mode_valid,
    output logic [ddrci_pkg::MR_SEL_W-1:0] mode_sel,
    output logic [ddrci_pkg::ADDR_W-1:0] mode_value,
    // Accepted write data
    output logic wr_valid,
    output logic [ddrci_pkg::DQ_W-1:0] wr_data,
    output logic [ddrci_pkg::DM_W-1:0] wr_byte_en,
    // Device state
    output logic [ddrci_pkg::BANKS-1:0] bank_open,
    output logic [1:0] power_state,
    output logic clocks_enabled,
    output logic cmd_buf_en,
    output logic ck_buf_en,
    output logic odt_on
);
    localparam int SYNC_W = 8 + ddrci_pkg::BA_W + ddrci_pkg::ADDR_W
        + ddrci_pkg::DQ_W + ddrci_pkg::DM_W;

    typedef struct packed {
        ddrci_pkg::ddrci_power_type pwr;
        logic ck_t_prev;
        logic ck_c_prev;
        logic [ddrci_pkg::BANKS-1:0] bank_open;
        logic [ddrci_pkg::MR_COUNT-1:0][ddrci_pkg::ADDR_W-1:0] mr;
        logic [3:0] wr_left;
        logic act_valid;
        logic [ddrci_pkg::BA_W-1:0] act_bank;
        logic [ddrci_pkg::ADDR_W-1:0] act_row;
        logic rw_valid;
        logic rw_write;
        logic [ddrci_pkg::BA_W-1:0] rw_bank;
        logic [ddrci_pkg::ADDR_W-1:0] rw_col;
        logic rw_auto_pre;
        logic rw_burst_full;
        logic pre_valid;
        logic pre_all;
        logic [ddrci_pkg::BA_W-1:0] pre_bank;
        logic mode_valid;
        logic [ddrci_pkg::MR_SEL_W-1:0] mode_sel;
        logic [ddrci_pkg::ADDR_W-1:0] mode_value;
        logic wr_valid;
        logic [ddrci_pkg::DQ_W-1:0] wr_data;
        logic [ddrci_pkg::DM_W-1:0] wr_byte_en;
        logic clocks_enabled;
        logic cmd_buf_en;
        logic ck_buf_en;
        logic odt_on;
    } ddrci_state_type;

    ddrci_state_type s;
    ddrci_state_type next_s;

    logic [SYNC_W-1:0] sync_q;
    logic ck_t_s;
    logic ck_c_s;
    logic cke_s;
    logic cs_n_s;
    logic [2:0] cmd_s;
    logic odt_s;
    logic [ddrci_pkg::BA_W-1:0] ba_s;
    logic [ddrci_pkg::ADDR_W-1:0] addr_s;
    logic [ddrci_pkg::DQ_W-1:0] dq_s;
    logic [ddrci_pkg::DM_W-1:0] dm_s;
    logic crossing;
    logic selected;
    logic odt_allowed;
    logic [1:0] bl_mode;
    logic [3:0] burst_len;

    // Every pin is synchronised with the same latency, so the group stays
    // aligned to the sampled clock pair
    ddrci_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d({ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, odt,
            ba, addr, dq, dm}),
        .q(sync_q)
    );

    assign {ck_t_s, ck_c_s, cke_s, cs_n_s, cmd_s, odt_s,
            ba_s, addr_s, dq_s, dm_s} = sync_q;

    // True rising and complement falling seen together
    assign crossing = ck_t_s && !s.ck_t_prev
        && !ck_c_s && s.ck_c_prev;
    assign selected = !cs_n_s;
    assign odt_allowed = s.mr[1][ddrci_pkg::MR1_RTT_BIT0]
        || s.mr[1][ddrci_pkg::MR1_RTT_BIT1]
        || s.mr[1][ddrci_pkg::MR1_RTT_BIT2];
    assign bl_mode = s.mr[0][ddrci_pkg::MR0_BL_LSB +: 2];

    always_comb begin
        burst_len = ddrci_pkg::BURST_FULL;
        if (bl_mode == ddrci_pkg::BL_FIXED_4) begin
            burst_len = ddrci_pkg::BURST_CHOPPED;
        end else if (bl_mode == ddrci_pkg::BL_ON_FLY) begin
            burst_len = addr_s[ddrci_pkg::BURST_CHOP_BIT]
                ? ddrci_pkg::BURST_FULL
                : ddrci_pkg::BURST_CHOPPED;
        end
    end

    always_comb begin
        next_s = s;
        next_s.ck_t_prev = ck_t_s;
        next_s.ck_c_prev = ck_c_s;
        next_s.act_valid = 1'b0;
        next_s.rw_valid = 1'b0;
        next_s.pre_valid = 1'b0;
        next_s.mode_valid = 1'b0;
        next_s.wr_valid = 1'b0;
        case (s.pwr)
            ddrci_pkg::PWR_SELF_REFRESH: begin
                // Only clock enable is looked at; exit needs no clock edge
                next_s.odt_on = 1'b0;
                if (cke_s) begin
                    next_s.pwr = ddrci_pkg::PWR_ACTIVE;
                end
            end
            ddrci_pkg::PWR_PD_PRECHARGE, ddrci_pkg::PWR_PD_ACTIVE: begin
                if (crossing) begin
                    next_s.odt_on = odt_allowed && odt_s;
                    if (cke_s) begin
                        next_s.pwr = ddrci_pkg::PWR_ACTIVE;
                    end
                end
            end
            default: begin
                if (crossing) begin
                    next_s.odt_on = odt_allowed && odt_s;
                    if (s.wr_left != 4'h0) begin
                        next_s.wr_left = s.wr_left - 4'h1;
                        next_s.wr_valid = (~dm_s) != '0;
                        next_s.wr_data = dq_s;
                        next_s.wr_byte_en = ~dm_s;
                    end
                    if (!cke_s) begin
                        // Power-down entry is taken on the crossing
                        if (selected && cmd_s == ddrci_pkg::CMD_REFRESH) begin
                            next_s.pwr = ddrci_pkg::PWR_SELF_REFRESH;
                            next_s.wr_left = 4'h0;
                            next_s.odt_on = 1'b0;
                        end else if (s.bank_open != '0) begin
                            next_s.pwr = ddrci_pkg::PWR_PD_ACTIVE;
                        end else begin
                            next_s.pwr = ddrci_pkg::PWR_PD_PRECHARGE;
                        end
                    end else if (selected) begin
                        case (cmd_s)
                            ddrci_pkg::CMD_ACTIVATE: begin
                                next_s.act_valid = 1'b1;
                                next_s.act_bank = ba_s;
                                next_s.act_row = addr_s;
                                next_s.bank_open[ba_s] = 1'b1;
                            end
                            ddrci_pkg::CMD_READ, ddrci_pkg::CMD_WRITE: begin
                                next_s.rw_valid = 1'b1;
                                next_s.rw_write =
                                    cmd_s == ddrci_pkg::CMD_WRITE;
                                next_s.rw_bank = ba_s;
                                next_s.rw_col = addr_s;
                                next_s.rw_auto_pre =
                                    addr_s[ddrci_pkg::AUTO_PRE_BIT];
                                next_s.rw_burst_full =
                                    burst_len == ddrci_pkg::BURST_FULL;
                                if (cmd_s == ddrci_pkg::CMD_WRITE) begin
                                    next_s.wr_left = burst_len;
                                end
                                // Auto-precharge closes the bank at issue
                                if (addr_s[ddrci_pkg::AUTO_PRE_BIT]) begin
                                    next_s.bank_open[ba_s] = 1'b0;
                                end
                            end
                            ddrci_pkg::CMD_PRECHARGE: begin
                                next_s.pre_valid = 1'b1;
                                next_s.pre_all =
                                    addr_s[ddrci_pkg::AUTO_PRE_BIT];
                                next_s.pre_bank = ba_s;
                                if (addr_s[ddrci_pkg::AUTO_PRE_BIT]) begin
                                    next_s.bank_open = '0;
                                end else begin
                                    next_s.bank_open[ba_s] = 1'b0;
                                end
                            end
                            ddrci_pkg::CMD_LOAD_MODE: begin
                                next_s.mode_valid = 1'b1;
                                next_s.mode_sel =
                                    ba_s[ddrci_pkg::MR_SEL_W-1:0];
                                next_s.mode_value = addr_s;
                                next_s.mr[ba_s[ddrci_pkg::MR_SEL_W-1:0]] =
                                    addr_s;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
        endcase
        // Buffer enables follow the state being entered
        next_s.clocks_enabled = next_s.pwr == ddrci_pkg::PWR_ACTIVE;
        next_s.cmd_buf_en = next_s.pwr == ddrci_pkg::PWR_ACTIVE;
        next_s.ck_buf_en =
            next_s.pwr != ddrci_pkg::PWR_SELF_REFRESH;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign act_valid = s.act_valid;
    assign act_bank = s.act_bank;
    assign act_row = s.act_row;
    assign rw_valid = s.rw_valid;
    assign rw_write = s.rw_write;
    assign rw_bank = s.rw_bank;
    assign rw_col = s.rw_col;
    assign rw_auto_pre = s.rw_auto_pre;
    assign rw_burst_full = s.rw_burst_full;
    assign pre_valid = s.pre_valid;
    assign pre_all = s.pre_all;
    assign pre_bank = s.pre_bank;
    assign mode_valid = s.mode_valid;
    assign mode_sel = s.mode_sel;
    assign mode_value = s.mode_value;
    assign wr_valid = s.wr_valid;
    assign wr_data = s.wr_data;
    assign wr_byte_en = s.wr_byte_en;
    assign bank_open = s.bank_open;
    assign power_state = s.pwr;
    assign clocks_enabled = s.clocks_enabled;
    assign cmd_buf_en = s.cmd_buf_en;
    assign ck_buf_en = s.ck_buf_en;
    assign odt_on = s.odt_on;
endmodule
`default_nettype wire

// >>> design/ddrci_pkg.sv
// Shared constants and types for the DDR3 command interface
package ddrci_pkg;
    localparam int ADDR_W = 16;
    localparam int BA_W = 3;
    localparam int BANKS = 8;
    localparam int DQ_W = 16;
    localparam int DM_W = 2;
    localparam int MR_COUNT = 4;
    localparam int MR_SEL_W = 2;
    // Address bit positions with a special meaning
    localparam int AUTO_PRE_BIT = 10;
    localparam int BURST_CHOP_BIT = 12;
    // Command code {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_ZQ_CAL = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;
    // Mode register 0 burst length field and codes
    localparam int MR0_BL_LSB = 0;
    localparam logic [1:0] BL_FIXED_8 = 2'h0;
    localparam logic [1:0] BL_ON_FLY = 2'h1;
    localparam logic [1:0] BL_FIXED_4 = 2'h2;
    // Mode register 1 nominal termination bits
    localparam int MR1_RTT_BIT0 = 2;
    localparam int MR1_RTT_BIT1 = 6;
    localparam int MR1_RTT_BIT2 = 9;
    // Burst lengths in data items
    localparam logic [3:0] BURST_FULL = 4'h8;
    localparam logic [3:0] BURST_CHOPPED = 4'h4;
    localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_PD_PRECHARGE,
        PWR_PD_ACTIVE,
        PWR_SELF_REFRESH
    } ddrci_power_type;
endpackage

// >>> design/ddrci_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module ddrci_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Pin side and synchronised side
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/ddrci_core_monitor.sv
// Checker on the DDR3 command interface ports
`timescale 1ns/1ns
`default_nettype none
module ddrci_core_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Pins
    input wire logic ck_t,
    input wire logic ck_c,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt,
    input wire logic [2:0] ba,
    input wire logic [15:0] addr,
    input wire logic [1:0] dm,
    // Reports
    input wire logic act_valid,
    input wire logic [2:0] act_bank,
    input wire logic [15:0] act_row,
    input wire logic rw_valid,
    input wire logic rw_auto_pre,
    input wire logic pre_valid,
    input wire logic pre_all,
    input wire logic mode_valid,
    input wire logic [1:0] mode_sel,
    input wire logic [15:0] mode_value,
    input wire logic wr_valid,
    input wire logic [1:0] wr_byte_en,
    // State
    input wire logic [7:0] bank_open,
    input wire logic [1:0] power_state,
    input wire logic cmd_buf_en,
    input wire logic ck_buf_en,
    input wire logic odt_on
);
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] p;
    logic x;
    logic go;
    logic [2:0] c;
    // Own copy of the pin synchroniser, so crossings line up with the design
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 2'h0;
            s2 <= 2'h0;
            p <= 2'h0;
        end else begin
            s1 <= {ck_t, ck_c};
            s2 <= s1;
            p <= s2;
        end
    end
    assign x = s2[1] & ~p[1] & ~s2[0] & p[0];
    assign c = {ras_n, cas_n, we_n};
    assign go = x & ~cs_n & cke & (power_state == 2'h0);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    act_report_a: assert property (
        go && c == ddrci_pkg::CMD_ACTIVATE |=> act_valid
        && act_bank == $past(ba) && act_row == $past(addr))
        else $error("activate report wrong");
    cs_mask_a: assert property (
        x && cs_n |=> !act_valid && !rw_valid && !pre_valid && !mode_valid)
        else $error("deselected command executed");
    rw_report_a: assert property (
        go && (c == ddrci_pkg::CMD_READ || c == ddrci_pkg::CMD_WRITE)
        |=> rw_valid && rw_auto_pre == $past(addr[10]))
        else $error("read or write report wrong");
    pre_report_a: assert property (
        go && c == ddrci_pkg::CMD_PRECHARGE |=> pre_valid
        && pre_all == $past(addr[10]) && !bank_open[$past(ba)])
        else $error("precharge wrong");
    mode_report_a: assert property (
        go && c == ddrci_pkg::CMD_LOAD_MODE |=> mode_valid
        && mode_sel == $past(ba[1:0]) && mode_value == $past(addr))
        else $error("mode load wrong");
    sr_entry_a: assert property (
        x && power_state == 2'h0 && !cke && !cs_n
        && c == ddrci_pkg::CMD_REFRESH
        |=> power_state == 2'h3 && !ck_buf_en && !cmd_buf_en)
        else $error("self refresh entry wrong");
    pd_entry_a: assert property (
        x && power_state == 2'h0 && !cke
        && (cs_n || c != ddrci_pkg::CMD_REFRESH)
        |=> power_state == ((|$past(bank_open)) ? 2'h2 : 2'h1)
        && !cmd_buf_en && ck_buf_en)
        else $error("power-down entry wrong");
    sr_exit_a: assert property (
        power_state == 2'h3 ##0 cke [*3] |=> power_state == 2'h0)
        else $error("self refresh exit late");
    odt_off_a: assert property (
        x && !odt && power_state != 2'h3 |=> !odt_on)
        else $error("termination left on");
    sr_odt_off_a: assert property (
        power_state == 2'h3 |-> !odt_on)
        else $error("termination on in self refresh");
    wr_mask_a: assert property (
        wr_valid |-> wr_byte_en == ~$past(dm) && wr_byte_en != 2'h0)
        else $error("masked write data kept");
endmodule
bind ddrci_core ddrci_core_monitor mon (.*);
`default_nettype wire

// >>> testbench/ddrci_ctrl_model.sv
// Controller-side pin model for the DDR3 command interface
`timescale 1ns/1ns
`default_nettype none
module ddrci_ctrl_model (
    // Clock
    input wire logic clk_sys,
    // Link clock pair
    output logic ck_t,
    output logic ck_c,
    // Control and address
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic odt,
    output logic [2:0] ba,
    output logic [15:0] addr,
    // Write data
    output logic [15:0] dq,
    output logic [1:0] dm
);
    // Slow stand-in for the 400 MHz link, still between crossings
    initial begin
        ck_t = 1'b0;
        ck_c = 1'b1;
        {cke, cs_n, ras_n, cas_n, we_n, odt} = 6'h3e;
        ba = 3'h0;
        addr = 16'h0000;
        dq = 16'h0000;
        dm = 2'h0;
    end
    // One crossing; pins held four edges before it and three after it
    task automatic xing(input logic [2:0] c, input logic [2:0] b,
        input logic [15:0] a, input logic [2:0] k,
        input logic [15:0] d, input logic [1:0] m);
        @(posedge clk_sys);
        ck_t <= 1'b0;
        ck_c <= 1'b1;
        {ras_n, cas_n, we_n} <= c;
        {cke, cs_n, odt} <= k;
        ba <= b;
        addr <= a;
        dq <= d;
        dm <= m;
        repeat (4) @(posedge clk_sys);
        ck_t <= 1'b1;
        ck_c <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    // Self refresh exit needs no crossing
    task automatic cke_up();
        @(posedge clk_sys);
        cke <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> testbench/ddrci_core_tb.sv
// Self-checking bench for the DDR3 command interface
`timescale 1ns/1ns
`default_nettype none
module ddrci_core_tb;
    localparam logic [2:0] ON = 3'h4;
    localparam logic [2:0] DES = 3'h6;
    localparam logic [2:0] LOW = 3'h2;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, odt;
    logic [2:0] ba, act_bank, rw_bank, pre_bank;
    logic [15:0] addr, dq, act_row, rw_col, mode_value, wr_data;
    logic [1:0] dm, mode_sel, wr_byte_en, power_state;
    logic [7:0] bank_open;
    logic act_valid, rw_valid, rw_write, rw_auto_pre, rw_burst_full;
    logic pre_valid, pre_all, mode_valid, wr_valid, clocks_enabled;
    logic cmd_buf_en, ck_buf_en, odt_on;
    int fails = 0;
    int num_checks = 0;
    ddrci_core DUT (.*);
    ddrci_ctrl_model ctl (.*);
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [2:0] c, input logic [2:0] b,
        input logic [15:0] a, input logic [2:0] k);
        ctl.xing(c, b, a, k, 16'hffff, 2'h3);
    endtask
    // Nine crossings after a write; only the first n carry data
    task automatic burst(input int n);
        logic [1:0] m;
        for (int i = 0; i < 9; i++) begin
            m = i[1:0];
            ctl.xing(ddrci_pkg::CMD_NOP, 3'h0, 16'h0000, DES,
                16'ha500 + 16'(i), m);
            chk("wr_valid", wr_valid, i < n && m != 2'h3);
            if (i < n && m != 2'h3) begin
                chk("wr_data", wr_data, 16'ha500 + 16'(i));
                chk("wr_byte_en", wr_byte_en, 2'(~m));
            end
        end
    endtask
    task automatic t_act();
        cmd(ddrci_pkg::CMD_ACTIVATE, 3'h5, 16'h1234, ON);
        chk("act_valid", act_valid, 1'b1);
        chk("act_bank", act_bank, 3'h5);
        chk("act_row", act_row, 16'h1234);
        cmd(ddrci_pkg::CMD_ACTIVATE, 3'h2, 16'h0abc, DES);
        chk("act_valid", act_valid, 1'b0);
        chk("bank_open", bank_open, 8'h20);
    endtask
    task automatic t_write();
        cmd(ddrci_pkg::CMD_WRITE, 3'h5, 16'h0400, ON);
        chk("rw_write", rw_write, 1'b1);
        chk("rw_col", rw_col, 16'h0400);
        chk("rw_burst_full", rw_burst_full, 1'b1);
        chk("bank_open", bank_open, 8'h00);
        burst(8);
    endtask
    task automatic t_chop();
        cmd(ddrci_pkg::CMD_LOAD_MODE, 3'h4, 16'h0001, ON);
        chk("mode_sel", mode_sel, 2'h0);
        chk("mode_value", mode_value, 16'h0001);
        cmd(ddrci_pkg::CMD_READ, 3'h1, 16'h1010, ON);
        chk("rw_burst_full", rw_burst_full, 1'b1);
        chk("rw_bank", rw_bank, 3'h1);
        cmd(ddrci_pkg::CMD_WRITE, 3'h3, 16'h0010, ON);
        chk("rw_burst_full", rw_burst_full, 1'b0);
        burst(4);
        // Fixed chop mode ignores A12
        cmd(ddrci_pkg::CMD_LOAD_MODE, 3'h0, 16'h0002, ON);
        cmd(ddrci_pkg::CMD_WRITE, 3'h3, 16'h1010, ON);
        chk("rw_burst_full", rw_burst_full, 1'b0);
        burst(4);
    endtask
    task automatic t_pre();
        cmd(ddrci_pkg::CMD_ACTIVATE, 3'h1, 16'h0001, ON);
        cmd(ddrci_pkg::CMD_ACTIVATE, 3'h2, 16'h0002, ON);
        cmd(ddrci_pkg::CMD_PRECHARGE, 3'h1, 16'h0000, ON);
        chk("pre_bank", pre_bank, 3'h1);
        chk("bank_open", bank_open, 8'h04);
        cmd(ddrci_pkg::CMD_PRECHARGE, 3'h0, 16'h0400, ON);
        chk("pre_all", pre_all, 1'b1);
        chk("bank_open", bank_open, 8'h00);
    endtask
    task automatic t_odt();
        cmd(ddrci_pkg::CMD_NOP, 3'h0, 16'h0000, 3'h7);
        chk("odt_on", odt_on, 1'b0);
        cmd(ddrci_pkg::CMD_LOAD_MODE, 3'h1, 16'h0004, ON);
        cmd(ddrci_pkg::CMD_NOP, 3'h0, 16'h0000, 3'h7);
        chk("odt_on", odt_on, 1'b1);
    endtask
    // Commands ignored in power-down, cke low throughout; self refresh exits on cke alone
    task automatic t_power();
        cmd(ddrci_pkg::CMD_ACTIVATE, 3'h3, 16'h0003, ON);
        cmd(ddrci_pkg::CMD_NOP, 3'h0, 16'h0000, LOW);
        chk("power_state", power_state, 2'h2);
        chk("cmd_buf_en", cmd_buf_en, 1'b0);
        cmd(ddrci_pkg::CMD_ACTIVATE, 3'h6, 16'h0006, 3'h0);
        cmd(ddrci_pkg::CMD_NOP, 3'h0, 16'h0000, ON);
        chk("power_state", power_state, 2'h0);
        chk("bank_open", bank_open, 8'h08);
        cmd(ddrci_pkg::CMD_PRECHARGE, 3'h0, 16'h0400, ON);
        cmd(ddrci_pkg::CMD_NOP, 3'h0, 16'h0000, LOW);
        chk("power_state", power_state, 2'h1);
        cmd(ddrci_pkg::CMD_NOP, 3'h0, 16'h0000, 3'h5);
        cmd(ddrci_pkg::CMD_REFRESH, 3'h0, 16'h0000, 3'h1);
        chk("power_state", power_state, 2'h3);
        chk("ck_buf_en", ck_buf_en, 1'b0);
        chk("odt_on", odt_on, 1'b0);
        ctl.cke_up();
        chk("power_state", power_state, 2'h0);
        chk("clocks_enabled", clocks_enabled, 1'b1);
    endtask
    initial begin
        #300000;
        fails++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("power_state", power_state, 2'h0);
        chk("ck_buf_en", ck_buf_en, 1'b1);
        t_act();
        t_write();
        t_chop();
        t_pre();
        t_odt();
        t_power();
        conclude();
    end
endmodule
`default_nettype wire
